// ===== ccpos_pkg.sv
package ccpos_pkg;
   // ***************************************************************
   // Register map (word offsets, APB byte addresses)
   // ***************************************************************
   localparam logic [7:0] ADDR_CAP_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CAPTURE    = 8'h04;
   localparam logic [7:0] ADDR_TB_CTRL    = 8'h08;
   localparam logic [7:0] ADDR_TB_COUNT   = 8'h0c;
   localparam logic [7:0] ADDR_OS_CTRL    = 8'h10;
   localparam logic [7:0] ADDR_PERIOD     = 8'h14;
   localparam logic [7:0] ADDR_PULSE      = 8'h18;
   localparam logic [7:0] ADDR_OS_COUNT   = 8'h1c;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
   localparam logic [7:0] ADDR_IRQ_MASK   = 8'h24;
   // ***************************************************************
   // Capture control fields
   // ***************************************************************
   localparam int          CAP_EN_BIT     = 7;
   localparam logic [3:0]  CAP_MODE_OFF   = 4'h0;
   localparam logic [3:0]  CAP_MODE_FALL  = 4'h4;
   localparam logic [3:0]  CAP_MODE_RISE  = 4'h5;
   localparam logic [3:0]  CAP_MODE_RISE4 = 4'h6;
   localparam logic [3:0]  CAP_MODE_RISE16 = 4'h7;
   localparam logic [3:0]  PRESC_DIV4     = 4'h3;
   localparam logic [3:0]  PRESC_DIV16    = 4'hf;
   // ***************************************************************
   // Timebase control fields
   // ***************************************************************
   localparam int          TB_ON_BIT      = 0;
   localparam int          TB_EXT_BIT     = 1;
   // ***************************************************************
   // One-shot timer fields
   // ***************************************************************
   localparam int          OS_ON_BIT      = 0;
   localparam int          OS_CCP_BIT     = 1;
   localparam int          OS_MODE_LSB    = 8;
   localparam logic [4:0]  OS_MODE_RISE   = 5'h09;
   localparam logic [4:0]  OS_MODE_FALL   = 5'h0a;
   localparam logic [4:0]  OS_MODE_BOTH   = 5'h0b;
   // ***************************************************************
   // Interrupt status bits
   // ***************************************************************
   localparam int          IRQ_CAP_BIT    = 0;
   localparam int          IRQ_OS_BIT     = 1;
   localparam int          IRQ_W          = 2;
   localparam logic [31:0] RESET_ZERO     = 32'h0000_0000;
endpackage : ccpos_pkg

// ===== ccpos_edge_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ccpos_edge_if;
   logic rise;
   logic fall;
   modport det (output rise, output fall);
   modport use_side (input rise, input fall);
endinterface : ccpos_edge_if
`default_nettype wire

// ===== ccpos_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module ccpos_edge_det (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       sig,
   ccpos_edge_if.det       edges
);
   typedef struct packed {
      logic last;
   } ccpos_ed_state_t;

   ccpos_ed_state_t st;
   ccpos_ed_state_t next_st;

   always_comb begin
      next_st      = st;
      next_st.last = sig;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Pins are taken as synchronous, so one stage suffices
   assign edges.rise = sig & ~st.last;
   assign edges.fall = ~sig & st.last;
endmodule : ccpos_edge_det
`default_nettype wire

// ===== ccpos_top.sv
// Functional notes
// [RULE_01] One-shot timer starts only after enable and then a qualifying trigger edge
// [RULE_02] One-shot clears its enable when count equals period register
// [RULE_03] Mode 01001 rising, 01010 falling, 01011 either edge starts one-shot
// [RULE_04] After software disable, re-enable needs a fresh trigger edge
// [RULE_05] With unit paired, start edge drives PWM output active
// [RULE_06] PWM goes inactive at pulse-width match, stays inactive through halt
// [RULE_07] Software runs timebase synchronized for capture to work
// [RULE_08] Changing capture mode may raise a spurious capture flag
// [RULE_09] Software masks capture interrupt while changing modes, then clears flag
// [RULE_10] Timebase for capture clocked from instruction clock or external source
// [RULE_11] Capture mode field gives four distinct prescaler settings
// [RULE_12] Prescaler counter held zero when unit off or not capturing
// [RULE_13] Every reset clears the prescaler counter
// [RULE_14] Prescaler change alone keeps the counter, may give spurious flag
// [RULE_15] Software clears control register before writing new prescaler
// [RULE_16] Instruction-clocked timebase stops incrementing during sleep
// [RULE_17] After wake the timebase resumes from its held value
// [RULE_18] Capture runs in sleep when timebase uses external clock
// [RULE_19] Each prescaled capture event copies timebase and sets capture flag
`timescale 1ns/1ps
`default_nettype none
module ccpos_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        capture_pin,
   input  wire logic        timer_external_trigger,
   input  wire logic        ext_clk_tick,
   input  wire logic        sleep,
   output logic             pwm_out,
   output logic             irq
);
   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed {
      logic [7:0]  capture_control_register;
      logic [15:0] capture_value;
      logic [1:0]  tb_ctrl;
      logic [15:0] tb_count;
      logic        os_on;
      logic        os_ccp;
      logic [4:0]  os_mode;
      logic        os_running;
      logic [15:0] period_register;
      logic [15:0] pulse_width_register;
      logic [15:0] period_timer_count;
      logic        pwm;
      logic [3:0]  presc_cnt;
      logic [1:0]  irq_status;
      logic [1:0]  irq_mask;
      logic [31:0] rdata;
   } ccpos_state_t;

   ccpos_state_t st;
   ccpos_state_t next_st;

   ccpos_edge_if cap_e ();
   ccpos_edge_if trg_e ();

   ccpos_edge_det u_cap_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .sig     (capture_pin),
      .edges   (cap_e.det)
   );

   ccpos_edge_det u_trg_edge (
      .pclk    (pclk),
      .presetn (presetn),
      .sig     (timer_external_trigger),
      .edges   (trg_e.det)
   );

   logic       wr;
   logic       rd;
   logic       cap_en;
   logic [3:0] cap_mode;
   logic       capturing;
   logic       cap_edge;
   logic [3:0] presc_lim;
   logic       cap_event;
   logic       tb_tick;
   logic       trig_ok;
   logic       os_tick;
   logic       period_hit;
   logic       pulse_hit;
   logic [1:0] set_bits;

   assign wr = psel & penable & pwrite;
   assign rd = psel & ~penable & ~pwrite;
   assign cap_en = st.capture_control_register[ccpos_pkg::CAP_EN_BIT];
   assign cap_mode = st.capture_control_register[3:0];
   assign capturing = cap_en && (cap_mode >= ccpos_pkg::CAP_MODE_FALL)
                      && (cap_mode <= ccpos_pkg::CAP_MODE_RISE16);

   // ***************************************************************
   // Capture prescaler
   // ***************************************************************
   always_comb begin
      unique case (cap_mode) // RULE_11
         ccpos_pkg::CAP_MODE_FALL: begin
            cap_edge  = cap_e.fall;
            presc_lim = 4'h0;
         end
         ccpos_pkg::CAP_MODE_RISE4: begin
            cap_edge  = cap_e.rise;
            presc_lim = ccpos_pkg::PRESC_DIV4;
         end
         ccpos_pkg::CAP_MODE_RISE16: begin
            cap_edge  = cap_e.rise;
            presc_lim = ccpos_pkg::PRESC_DIV16;
         end
         default: begin
            cap_edge  = cap_e.rise;
            presc_lim = 4'h0;
         end
      endcase
   end

   // Counter is not cleared on a limit change, so a lowered limit fires early
   assign cap_event = capturing && cap_edge && (st.presc_cnt >= presc_lim); // RULE_14

   // ***************************************************************
   // Timebase: internal ticks stop in sleep, external ones run on
   // ***************************************************************
   always_comb begin
      if (st.tb_ctrl[ccpos_pkg::TB_EXT_BIT]) begin
         tb_tick = st.tb_ctrl[ccpos_pkg::TB_ON_BIT] & ext_clk_tick; // RULE_18
      end else begin
         tb_tick = st.tb_ctrl[ccpos_pkg::TB_ON_BIT] & ~sleep; // RULE_16
      end
   end

   // ***************************************************************
   // One-shot timer
   // ***************************************************************
   always_comb begin
      unique case (st.os_mode) // RULE_03
         ccpos_pkg::OS_MODE_RISE: trig_ok = trg_e.rise;
         ccpos_pkg::OS_MODE_FALL: trig_ok = trg_e.fall;
         ccpos_pkg::OS_MODE_BOTH: trig_ok = trg_e.rise | trg_e.fall;
         default:                 trig_ok = 1'b0;
      endcase
   end

   assign os_tick    = st.os_on & st.os_running;
   assign period_hit = os_tick && (st.period_timer_count == st.period_register);
   assign pulse_hit  = os_tick && (st.period_timer_count == st.pulse_width_register);

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb begin
      next_st  = st;
      set_bits = '0;

      if (tb_tick) begin
         next_st.tb_count = st.tb_count + 16'h0001; // RULE_17
      end

      if (!capturing) begin
         next_st.presc_cnt = 4'h0; // RULE_12
      end else if (cap_edge) begin
         next_st.presc_cnt = cap_event ? 4'h0 : st.presc_cnt + 4'h1;
      end
      if (cap_event) begin
         next_st.capture_value = st.tb_count; // RULE_19
         set_bits[ccpos_pkg::IRQ_CAP_BIT] = 1'b1;
      end

      if (st.os_on && !st.os_running && trig_ok) begin
         next_st.os_running = 1'b1; // RULE_01
         if (st.os_ccp) begin
            next_st.pwm = 1'b1; // RULE_05
         end
      end
      if (os_tick) begin
         next_st.period_timer_count = st.period_timer_count + 16'h0001;
         if (pulse_hit) begin
            next_st.pwm = 1'b0; // RULE_06
         end
         if (period_hit) begin
            next_st.os_on              = 1'b0; // RULE_02
            next_st.os_running         = 1'b0;
            next_st.period_timer_count = 16'h0000;
            set_bits[ccpos_pkg::IRQ_OS_BIT] = 1'b1;
         end
      end

      if (wr) begin
         unique case (paddr)
            ccpos_pkg::ADDR_CAP_CTRL: begin
               next_st.capture_control_register = pwdata[7:0];
               // Any mode change may look like an edge; flag it as hardware does
               if (pwdata[3:0] != cap_mode) begin
                  set_bits[ccpos_pkg::IRQ_CAP_BIT] = 1'b1; // RULE_08
               end
            end
            ccpos_pkg::ADDR_TB_CTRL:  next_st.tb_ctrl = pwdata[1:0];
            ccpos_pkg::ADDR_TB_COUNT: next_st.tb_count = pwdata[15:0];
            ccpos_pkg::ADDR_OS_CTRL: begin
               next_st.os_on   = pwdata[ccpos_pkg::OS_ON_BIT];
               next_st.os_ccp  = pwdata[ccpos_pkg::OS_CCP_BIT];
               next_st.os_mode = pwdata[ccpos_pkg::OS_MODE_LSB +: 5];
               if (!pwdata[ccpos_pkg::OS_ON_BIT]) begin
                  next_st.os_running = 1'b0; // RULE_04
               end
            end
            ccpos_pkg::ADDR_PERIOD:    next_st.period_register = pwdata[15:0];
            ccpos_pkg::ADDR_PULSE:     next_st.pulse_width_register = pwdata[15:0];
            ccpos_pkg::ADDR_OS_COUNT:  next_st.period_timer_count = pwdata[15:0];
            ccpos_pkg::ADDR_IRQ_STATUS: next_st.irq_status = st.irq_status & ~pwdata[1:0];
            ccpos_pkg::ADDR_IRQ_MASK:  next_st.irq_mask = pwdata[1:0];
            default: begin
            end
         endcase
      end
      // Set wins over a same-cycle write-one clear
      next_st.irq_status = next_st.irq_status | set_bits;

      if (rd) begin
         unique case (paddr)
            ccpos_pkg::ADDR_CAP_CTRL:  next_st.rdata = {24'h0, st.capture_control_register};
            ccpos_pkg::ADDR_CAPTURE:   next_st.rdata = {16'h0, st.capture_value};
            ccpos_pkg::ADDR_TB_CTRL:   next_st.rdata = {30'h0, st.tb_ctrl};
            ccpos_pkg::ADDR_TB_COUNT:  next_st.rdata = {16'h0, st.tb_count};
            ccpos_pkg::ADDR_OS_CTRL:   next_st.rdata = {19'h0, st.os_mode, 5'h0,
                                                        st.os_running, st.os_ccp, st.os_on};
            ccpos_pkg::ADDR_PERIOD:    next_st.rdata = {16'h0, st.period_register};
            ccpos_pkg::ADDR_PULSE:     next_st.rdata = {16'h0, st.pulse_width_register};
            ccpos_pkg::ADDR_OS_COUNT:  next_st.rdata = {16'h0, st.period_timer_count};
            ccpos_pkg::ADDR_IRQ_STATUS: next_st.rdata = {30'h0, st.irq_status};
            ccpos_pkg::ADDR_IRQ_MASK:  next_st.rdata = {30'h0, st.irq_mask};
            default:                   next_st.rdata = ccpos_pkg::RESET_ZERO;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= '0; // RULE_13
      end else begin
         st <= next_st;
      end
   end

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign prdata  = st.rdata;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign pwm_out = st.pwm;
   assign irq     = |(st.irq_status & st.irq_mask);

   // ***************************************************************
   // Assertions
   // ***************************************************************
   presc_zero_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !capturing |=> st.presc_cnt == 4'h0)
      else $error("Prescaler not cleared while idle"); // RULE_12
   os_wait_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
      (st.os_on && !st.os_running && !trig_ok) |=> !st.os_running)
      else $error("One-shot started without trigger"); // RULE_01
   os_auto_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      (period_hit && !wr) |=> !st.os_on && st.period_timer_count == 16'h0000)
      else $error("One-shot did not halt at period"); // RULE_02
   os_rise_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
      (st.os_mode == ccpos_pkg::OS_MODE_RISE && st.os_on && !st.os_running
       && trg_e.fall) |=> !st.os_running)
      else $error("Rising mode started on fall"); // RULE_03
   os_rearm_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == ccpos_pkg::ADDR_OS_CTRL && !pwdata[0]) |=> !st.os_running)
      else $error("Disable did not disarm"); // RULE_04
   pwm_start_a: assert property (@(posedge pclk) disable iff (!presetn)
      (st.os_on && !st.os_running && trig_ok && st.os_ccp) |=> pwm_out)
      else $error("PWM not driven at start"); // RULE_05
   pwm_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      pulse_hit |=> !pwm_out ##1 (!pwm_out || st.os_running))
      else $error("PWM not released at pulse match"); // RULE_06
   tb_sleep_a: assert property (@(posedge pclk) disable iff (!presetn)
      (sleep && !st.tb_ctrl[ccpos_pkg::TB_EXT_BIT] && !wr) |=> $stable(st.tb_count))
      else $error("Timebase ran in sleep"); // RULE_16
   cap_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
      cap_event |=> st.capture_value == $past(st.tb_count)
                    && st.irq_status[ccpos_pkg::IRQ_CAP_BIT])
      else $error("Capture not stored"); // RULE_19
   mode_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      (wr && paddr == ccpos_pkg::ADDR_CAP_CTRL && pwdata[3:0] != cap_mode)
      |=> st.irq_status[ccpos_pkg::IRQ_CAP_BIT])
      else $error("Mode change flag missing"); // RULE_08

   cap_seen_c:  cover property (@(posedge pclk) disable iff (!presetn) cap_event);
   os_full_c:   cover property (@(posedge pclk) disable iff (!presetn) period_hit);
   pwm_pulse_c: cover property (@(posedge pclk) disable iff (!presetn) pulse_hit && st.pwm);
   irq_c:       cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule : ccpos_top
`default_nettype wire

// ===== ccpos_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ***************************************************************
// Capture pin and one-shot trigger source
// ***************************************************************
module ccpos_src_model (
   input  wire logic pclk,
   output logic      capture_pin,
   output logic      timer_external_trigger,
   output logic      ext_clk_tick
);
   initial begin
      capture_pin            = 1'b0;
      timer_external_trigger = 1'b0;
      ext_clk_tick           = 1'b0;
   end
   // Levels change just after an edge, then hold long enough to be seen
   task automatic cap_level(input logic lvl, input int gap);
      @(posedge pclk);
      capture_pin <= lvl;
      repeat (gap) @(posedge pclk);
   endtask : cap_level
   task automatic trig_level(input logic lvl);
      @(posedge pclk);
      timer_external_trigger <= lvl;
   endtask : trig_level
   // One-cycle ticks locked to pclk: a synchronized, divided count source
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         ext_clk_tick <= 1'b1;
         @(posedge pclk);
         ext_clk_tick <= 1'b0;
      end
   endtask : ticks
endmodule : ccpos_src_model
`default_nettype wire

// ===== ccp_capture_oneshot_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module ccp_capture_oneshot_timer_test;
   logic        pclk, presetn, psel, penable, pwrite, sleep;
   logic        pready, pslverr, capture_pin, trig, tick, pwm_out, irq, flag_m;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] x, d;
   logic [4:0]  m;
   logic [3:0]  mode_m;
   int          fail_count, compares, cycles, pwm_hi, psc, lim, seed;
   ccpos_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .capture_pin(capture_pin), .timer_external_trigger(trig),
      .ext_clk_tick(tick), .sleep(sleep), .pwm_out(pwm_out), .irq(irq));
   ccpos_src_model src (.pclk(pclk), .capture_pin(capture_pin),
      .timer_external_trigger(trig), .ext_clk_tick(tick));
   initial pclk = 1'b0;
   always #12.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         finish_test();
      end
   end
   // Sampled mid-cycle, away from the edge that launches the drive
   always @(negedge pclk) if (pwm_out === 1'b1) pwm_hi++;
   // ***************************************************************
   // Bus cycles and prescaler model
   // ***************************************************************
   task automatic apb(input logic wr_n, input logic [7:0] a, input logic [31:0] v);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr_n;
      paddr <= a;
      pwdata <= v;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      apb(1'b1, a, v);
   endtask : wr
   task automatic rdw(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
   endtask : rdw
   task automatic do_reset();
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      psc = 0;
      mode_m = 4'h0;
      flag_m = 1'b0;
   endtask : do_reset
   task automatic set_cap(input logic [7:0] v);
      wr(ccpos_pkg::ADDR_CAP_CTRL, {24'h0, v});
      if (v[3:0] != mode_m) flag_m = 1'b1;
      mode_m = v[3:0];
      lim = (v[3:0] == ccpos_pkg::CAP_MODE_RISE16) ? 16 :
            (v[3:0] == ccpos_pkg::CAP_MODE_RISE4) ? 4 : 1;
      if (!v[7] || v[3:2] != 2'b01) psc = 0;
   endtask : set_cap
   // Flag cleared after each mode change while the mask stays off
   task automatic clr();
      wr(ccpos_pkg::ADDR_IRQ_STATUS, 32'h3);
      flag_m = 1'b0;
   endtask : clr
   task automatic pulses(input int n);
      repeat (n) begin
         src.cap_level(1'b1, 2 + ($random(seed) & 3));
         src.cap_level(1'b0, 3);
         psc++;
         if (psc >= lim) begin
            psc = 0;
            flag_m = 1'b1;
         end
      end
   endtask : pulses
   task automatic flag_chk();
      rdw(ccpos_pkg::ADDR_IRQ_STATUS);
      `CHK(rd[0], flag_m)
   endtask : flag_chk
   task automatic os_on(input logic [4:0] md, input logic pair);
      wr(ccpos_pkg::ADDR_OS_CTRL, {19'h0, md, 6'h0, pair, 1'b1});
   endtask : os_on
   task automatic os_wait(input logic done, input logic [15:0] cnt);
      repeat (20) @(posedge pclk);
      rdw(ccpos_pkg::ADDR_IRQ_STATUS);
      `CHK(rd[1], done)
      rdw(ccpos_pkg::ADDR_OS_CTRL);
      `CHK({rd[2], rd[0]}, {1'b0, !done})
      rdw(ccpos_pkg::ADDR_OS_COUNT);
      `CHK(rd[15:0], cnt)
      wr(ccpos_pkg::ADDR_IRQ_STATUS, 32'h2);
   endtask : os_wait
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : finish_test
   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial begin
      seed = 32'hed6b;
      {psel, penable, pwrite, sleep, paddr, pwdata} = '0;
      do_reset();
      for (int a = 0; a < 11; a++) begin
         rdw(8'(a * 4));
         `CHK(rd, ccpos_pkg::RESET_ZERO)
         `CHK({pready, pslverr}, 2'b10)
      end
      // Timebase stopped so the captured count is exact; rise and fall differ
      wr(ccpos_pkg::ADDR_TB_CTRL, 32'h0);
      for (int i = 0; i < 2; i++) begin
         x = 16'($random(seed));
         set_cap({4'h8, ccpos_pkg::CAP_MODE_FALL + 4'(i)});
         clr();
         wr(ccpos_pkg::ADDR_TB_COUNT, {16'h0, x});
         src.cap_level(1'b1, 3);
         wr(ccpos_pkg::ADDR_TB_COUNT, {16'h0, ~x});
         src.cap_level(1'b0, 3);
         rdw(ccpos_pkg::ADDR_CAPTURE);
         `CHK(rd[15:0], (i == 1) ? x : ~x)
      end
      @(negedge pclk);
      `CHK(irq, 1'b0)
      wr(ccpos_pkg::ADDR_IRQ_MASK, 32'h1);
      @(negedge pclk);
      `CHK(irq, 1'b1)
      clr();
      @(negedge pclk);
      `CHK(irq, 1'b0)
      wr(ccpos_pkg::ADDR_IRQ_MASK, 32'h0);
      for (int i = 1; i < 4; i++) begin
         set_cap(8'h00);
         set_cap({4'h8, ccpos_pkg::CAP_MODE_FALL + 4'(i)});
         clr();
         pulses(lim - 1);
         flag_chk();
         pulses(1);
         flag_chk();
      end
      set_cap(8'h86);
      clr();
      pulses(2);
      set_cap(8'h87);
      flag_chk();
      clr();
      pulses(13);
      flag_chk();
      pulses(1);
      flag_chk();
      set_cap(8'h86);
      clr();
      pulses(2);
      set_cap(8'h06);
      set_cap(8'h86);
      clr();
      pulses(3);
      flag_chk();
      pulses(1);
      flag_chk();
      pulses(2);
      do_reset();
      set_cap(8'h86);
      clr();
      pulses(3);
      flag_chk();
      pulses(1);
      flag_chk();
      // Sleep with the internal tick, then with external ticks
      x = 16'($random(seed));
      wr(ccpos_pkg::ADDR_TB_CTRL, 32'h1);
      sleep <= 1'b1;
      wr(ccpos_pkg::ADDR_TB_COUNT, {16'h0, x});
      repeat (10) @(posedge pclk);
      rdw(ccpos_pkg::ADDR_TB_COUNT);
      `CHK(rd[15:0], x)
      sleep <= 1'b0;
      rdw(ccpos_pkg::ADDR_TB_COUNT);
      d = rd[15:0] - x;
      `CHK((d >= 16'h1 && d <= 16'h6), 1'b1)
      wr(ccpos_pkg::ADDR_TB_CTRL, 32'h3);
      sleep <= 1'b1;
      wr(ccpos_pkg::ADDR_TB_COUNT, {16'h0, x});
      set_cap(8'h85);
      clr();
      src.ticks(5);
      pulses(1);
      rdw(ccpos_pkg::ADDR_CAPTURE);
      `CHK(rd[15:0], x + 16'h5)
      flag_chk();
      // Sleep level is free here: the one-shot timer ignores it
      sleep <= 1'($random(seed));
      // One-shot, every start edge, paired with the PWM drive
      wr(ccpos_pkg::ADDR_PERIOD, 32'h5);
      wr(ccpos_pkg::ADDR_PULSE, 32'h3);
      pwm_hi = 0;
      for (int i = 0; i < 3; i++) begin
         m = ccpos_pkg::OS_MODE_RISE + 5'(i);
         os_on(m, 1'b1);
         os_wait(1'b0, 16'h0);
         src.trig_level(1'b1);
         os_wait(m != ccpos_pkg::OS_MODE_FALL, 16'h0);
         if (m != ccpos_pkg::OS_MODE_FALL) os_on(m, 1'b1);
         src.trig_level(1'b0);
         os_wait(m != ccpos_pkg::OS_MODE_RISE, 16'h0);
      end
      // Halt mid-run: a stale trigger level must not restart it
      os_on(ccpos_pkg::OS_MODE_RISE, 1'b0);
      src.trig_level(1'b1);
      repeat (2) @(posedge pclk);
      wr(ccpos_pkg::ADDR_OS_CTRL, 32'h0900);
      // A halted count is kept and resumes only after a fresh edge
      rdw(ccpos_pkg::ADDR_OS_COUNT);
      x = rd[15:0];
      `CHK(x != 16'h0, 1'b1)
      os_on(ccpos_pkg::OS_MODE_RISE, 1'b0);
      os_wait(1'b0, x);
      src.trig_level(1'b0);
      src.trig_level(1'b1);
      os_wait(1'b1, 16'h0);
      // Four paired pulses, each high while the count shows 0 to 3
      `CHK(pwm_hi, 16)
      finish_test();
   end
endmodule : ccp_capture_oneshot_timer_test
`default_nettype wire
